// ===== pci_to_local_bus_controller.sv
// host target port to local bus bridge with wishbone config registers
`timescale 1ns/1ps
`include "lbus_defs.svh"
module pci_to_local_bus_controller (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic tgt_req,
   input wire logic tgt_we,
   input wire logic tgt_burst,
   input wire logic [15:0] tgt_addr,
   input wire logic [3:0] tgt_be,
   input wire logic [31:0] tgt_wdata,
   output logic tgt_done,
   output logic tgt_retry,
   output logic tgt_abort,
   output logic [31:0] tgt_rdata,
   output logic [15:0] local_addr_pins_o,
   output logic local_addr_pins_oe,
   input wire logic [15:0] local_data_pins_i,
   output logic [15:0] local_data_pins_o,
   output logic [1:0] local_data_pins_oe,
   output logic addr_latch_strobe,
   output logic read_strobe_n_o,
   output logic write_strobe_n_o,
   output logic byte_high_enable_n_o,
   output logic cmd_oe,
   input wire logic ready_in_n,
   input wire logic hold_req_n,
   output logic hold_ack_n,
   output logic bus_req_n
);
   logic [`LB_CONF_BITS-1:0] conf_r;
   logic ack_r;
   logic [1:0] sync1_r;
   logic [1:0] sync2_r;
   logic [15:0] din1_r;
   logic [15:0] din2_r;
   logic ans_r;
   logic done_r, retry_r, abort_r;
   logic [31:0] rdata_r;
   logic wr_pend_r, rd_pend_r, rd_valid_r;
   logic [15:0] job_addr_r;
   logic [1:0] job_be_r;
   logic [15:0] job_wdata_r;
   logic [15:0] rbuf_r;
   logic job_we_r;
   logic second_r;
   logic cyc_w16_r, cyc_mux_r, cyc_rdy_r;
   logic [3:0] cyc_ctw_r;
   logic wdrive_r;
   logic [15:0] wout_r;
   logic cap_r, cap_hi_r;
   lbus_pkg::lb_state_t state_r, state_nxt;
   logic [15:0] last_addr_r;
   logic take, rd_hit, pend, cur_hi, tmr_load, tmr_last;
   logic [15:0] cur_addr;
   logic [7:0] lane;
   logic [4:0] strobe_len;
   logic rdy_s, hold_s, pci_mode, owner;

   assign pci_mode = conf_r[`LB_F_PCI];
   assign rdy_s = sync2_r[0];
   assign hold_s = sync2_r[1];

   // wishbone slave: one wait state, ack drops the cycle after
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
      end
   end
   assign wb_ack_o = ack_r;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         conf_r <= `LB_CONF_BITS'(`LB_CONF_RST);
      end else if (wb_cyc_i && wb_stb_i && !ack_r && wb_we_i
                   && wb_adr_i == `LB_CONF_OFS) begin
         if (wb_sel_i[0]) conf_r[7:0] <= wb_dat_i[7:0];
         if (wb_sel_i[1]) conf_r[12:8] <= wb_dat_i[12:8];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (wb_cyc_i && wb_stb_i && !ack_r) begin
         case (wb_adr_i)
            `LB_CONF_OFS: wb_dat_o <= {19'h0_0000, conf_r};
            `LB_STAT_OFS: wb_dat_o <= {26'h000_0000, !owner,
                  rd_valid_r, rd_pend_r, wr_pend_r,
                  state_r != lbus_pkg::ST_IDLE, pci_mode};
            default: wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // pin inputs pass two flops before use
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sync1_r <= 2'h3;
         sync2_r <= 2'h3;
         din1_r <= 16'h0000;
         din2_r <= 16'h0000;
      end else begin
         sync1_r <= {hold_req_n, ready_in_n};
         sync2_r <= sync1_r;
         din1_r <= local_data_pins_i;
         din2_r <= din1_r;
      end
   end

   // host target side: request held until a one-cycle answer
   assign take = tgt_req && !ans_r;
   assign rd_hit = rd_valid_r && job_addr_r == tgt_addr
                   && job_be_r == tgt_be[1:0] && !cap_r;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ans_r <= 1'b0;
         done_r <= 1'b0;
         retry_r <= 1'b0;
         abort_r <= 1'b0;
      end else begin
         ans_r <= take;
         done_r <= 1'b0;
         retry_r <= 1'b0;
         abort_r <= 1'b0;
         if (take) begin
            // bursts and non-pci mode are refused
            if (tgt_burst || !pci_mode) begin
               abort_r <= 1'b1;
            end else if (tgt_we) begin
               retry_r <= wr_pend_r || rd_pend_r;
               done_r <= !(wr_pend_r || rd_pend_r);
            end else begin
               // retry until the read result is ready
               done_r <= rd_hit;
               retry_r <= !rd_hit;
            end
         end
      end
   end
   assign tgt_done = done_r;
   assign tgt_retry = retry_r;
   assign tgt_abort = abort_r;
   assign tgt_rdata = rdata_r;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         rd_valid_r <= 1'b0;
         job_we_r <= 1'b0;
         job_addr_r <= 16'h0000;
         job_be_r <= 2'h0;
         job_wdata_r <= 16'h0000;
         rdata_r <= 32'h0000_0000;
      end else begin
         if (take && !tgt_burst && pci_mode) begin
            if (tgt_we && !wr_pend_r && !rd_pend_r) begin
               wr_pend_r <= tgt_be[1:0] != 2'h0;
               rd_valid_r <= 1'b0;
               job_we_r <= 1'b1;
               job_addr_r <= tgt_addr;
               job_be_r <= tgt_be[1:0];
               job_wdata_r <= tgt_wdata[15:0];
            end else if (!tgt_we && rd_hit) begin
               rd_valid_r <= 1'b0;
               rdata_r <= {16'h0000, rbuf_r};
            end else if (!tgt_we && !wr_pend_r && !rd_pend_r) begin
               // start the local read behind the retry
               rd_pend_r <= tgt_be[1:0] != 2'h0;
               rd_valid_r <= tgt_be[1:0] == 2'h0;
               job_we_r <= 1'b0;
               job_addr_r <= tgt_addr;
               job_be_r <= tgt_be[1:0];
            end
         end
         // cycle end must not be lost to a request in the same clock;
         // such a request sees pend and is retried, so no field clashes
         if (tmr_last && state_r == lbus_pkg::ST_STROBE
             && !cyc_rdy_r || state_r == lbus_pkg::ST_RDY
             && !rdy_s) begin
            if (!(!cyc_w16_r && job_be_r == 2'h3 && !second_r)) begin
               wr_pend_r <= 1'b0;
               rd_pend_r <= 1'b0;
               rd_valid_r <= !job_we_r;
            end
         end
      end
   end

   assign pend = wr_pend_r || rd_pend_r;

   // byte lane choice; on 8-bit one byte per cycle
   assign cur_hi = cyc_w16_r ? (job_be_r == 2'h2)
                   : (second_r || !job_be_r[0]);
   assign cur_addr = {job_addr_r[15:1], cur_hi};
   assign lane = cur_hi ? job_wdata_r[15:8] : job_wdata_r[7:0];
   assign strobe_len = `LB_STROBE_MIN + `LB_CTW_MAX
                       - {1'b0, cyc_ctw_r}
                       + (cyc_rdy_r ? {2'h0, conf_r[7:5]}
                          : 5'h00);
   // slave mode always yields to hold, master only with hold enable
   assign owner = state_r != lbus_pkg::ST_HOLD;

   always_comb begin
      state_nxt = state_r;
      tmr_load = 1'b0;
      case (state_r)
         lbus_pkg::ST_IDLE: begin
            if (!pci_mode) begin
               state_nxt = lbus_pkg::ST_IDLE;
            end else if (!hold_s && (conf_r[`LB_F_HLDEN]
                         || !conf_r[`LB_F_ARBM])) begin
               state_nxt = lbus_pkg::ST_HOLD;
            end else if (pend) begin
               state_nxt = conf_r[`LB_F_MUX] ? lbus_pkg::ST_ALE
                           : lbus_pkg::ST_AHOLD;
            end
         end
         lbus_pkg::ST_ALE: state_nxt = lbus_pkg::ST_AHOLD;
         lbus_pkg::ST_AHOLD: begin
            state_nxt = lbus_pkg::ST_STROBE;
            tmr_load = 1'b1;
         end
         lbus_pkg::ST_STROBE: begin
            if (tmr_last) begin
               state_nxt = cyc_rdy_r ? lbus_pkg::ST_RDY
                           : lbus_pkg::ST_IDLE;
            end
         end
         lbus_pkg::ST_RDY: begin
            if (!rdy_s) begin
               state_nxt = lbus_pkg::ST_IDLE;
            end
         end
         lbus_pkg::ST_HOLD: begin
            if (hold_s) begin
               state_nxt = lbus_pkg::ST_IDLE;
            end
         end
         default: state_nxt = lbus_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_r <= lbus_pkg::ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   lb_cycle_timer #(.W(5)) u_timer (
      .ref_clk(ref_clk),
      .rst(rst),
      .load(tmr_load),
      .load_val(strobe_len),
      .last(tmr_last)
   );

   // latch the bus type at the start of each cycle
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cyc_w16_r <= 1'b1;
         cyc_mux_r <= 1'b0;
         cyc_rdy_r <= 1'b0;
         cyc_ctw_r <= 4'hF;
      end else if (state_r == lbus_pkg::ST_IDLE && pend) begin
         cyc_w16_r <= conf_r[`LB_F_W16];
         cyc_mux_r <= conf_r[`LB_F_MUX];
         cyc_rdy_r <= conf_r[`LB_F_READY_HANDLING_ENABLE];
         cyc_ctw_r <= conf_r[3:0];
      end
   end

   // second byte of a word on an 8-bit bus
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         second_r <= 1'b0;
      end else if (state_nxt == lbus_pkg::ST_IDLE
                   && state_r != lbus_pkg::ST_IDLE
                   && state_r != lbus_pkg::ST_HOLD) begin
         second_r <= !cyc_w16_r && job_be_r == 2'h3 && !second_r;
      end
   end

   // pins sampled one clock before the strobe rises leave the
   // two sync flops one edge after it; capture then
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cap_r <= 1'b0;
         cap_hi_r <= 1'b0;
      end else begin
         cap_r <= !job_we_r && (state_r == lbus_pkg::ST_STROBE
                  && tmr_last && !cyc_rdy_r
                  || state_r == lbus_pkg::ST_RDY && !rdy_s);
         cap_hi_r <= cur_hi;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rbuf_r <= 16'h0000;
      end else if (cap_r) begin
         if (cyc_w16_r) begin
            rbuf_r <= {job_be_r[1] ? din2_r[15:8] : 8'h00,
                       job_be_r[0] ? din2_r[7:0] : 8'h00};
         end else if (cap_hi_r) begin
            rbuf_r[15:8] <= din2_r[7:0];
         end else begin
            rbuf_r <= {8'h00, din2_r[7:0]};
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         last_addr_r <= 16'h0000;
      end else if (state_nxt == lbus_pkg::ST_ALE
                   || state_nxt == lbus_pkg::ST_AHOLD
                   && state_r == lbus_pkg::ST_IDLE) begin
         last_addr_r <= {job_addr_r[15:1],
            conf_r[`LB_F_W16] ? job_be_r == 2'h2
            : (second_r || !job_be_r[0])};
      end
   end

   // write data stays driven until the next cycle or a hold; a wait of over one clock in ST_RDY drops it
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wdrive_r <= 1'b0;
         wout_r <= 16'h0000;
      end else if (state_r == lbus_pkg::ST_STROBE && job_we_r) begin
         wdrive_r <= 1'b1;
         // keep what the strobe wrote; lane select and job move on after
         wout_r <= cyc_w16_r ? job_wdata_r : {8'h00, lane};
      end else if (state_nxt != lbus_pkg::ST_IDLE) begin
         wdrive_r <= 1'b0;
      end
   end

   assign local_addr_pins_o = last_addr_r;
   assign local_addr_pins_oe = owner && pci_mode;
   // latch strobe first, falls before the command strobe
   assign addr_latch_strobe = state_r == lbus_pkg::ST_ALE;
   assign cmd_oe = owner && pci_mode;
   assign read_strobe_n_o = !(!job_we_r &&
      (state_r == lbus_pkg::ST_STROBE || state_r == lbus_pkg::ST_RDY));
   assign write_strobe_n_o = !(job_we_r &&
      (state_r == lbus_pkg::ST_STROBE || state_r == lbus_pkg::ST_RDY));
   // upper byte enable only on a 16-bit bus
   assign byte_high_enable_n_o = !(cyc_w16_r && job_be_r[1]);
   assign hold_ack_n = owner;
   assign bus_req_n = !(!owner && pend);

   always_comb begin
      local_data_pins_o = 16'h0000;
      local_data_pins_oe = 2'h0;
      if (state_r == lbus_pkg::ST_ALE || state_r == lbus_pkg::ST_AHOLD
          && cyc_mux_r) begin
         local_data_pins_o = last_addr_r;
         local_data_pins_oe = cyc_w16_r ? 2'h3 : 2'h1;
      end else if (state_r != lbus_pkg::ST_HOLD
                   && (job_we_r && state_r != lbus_pkg::ST_IDLE
                       && state_r != lbus_pkg::ST_AHOLD || wdrive_r)) begin
         if (wdrive_r && state_r == lbus_pkg::ST_IDLE) begin
            local_data_pins_o = wout_r;
         end else begin
            local_data_pins_o = cyc_w16_r ? job_wdata_r : {8'h00, lane};
         end
         local_data_pins_oe = cyc_w16_r ? 2'h3 : 2'h1;
      end
      // upper pins keep the address in 8-bit multiplexed mode
      if (cyc_mux_r && !cyc_w16_r && owner
          && state_r != lbus_pkg::ST_IDLE) begin
         local_data_pins_o[15:8] = last_addr_r[15:8];
         local_data_pins_oe[1] = 1'b1;
      end
      if (!pci_mode) begin
         local_data_pins_oe = 2'h0;
      end
   end

   // checks
   logic [4:0] low_cnt_r;
   always_ff @(posedge ref_clk) begin
      if (rst || read_strobe_n_o && write_strobe_n_o) begin
         low_cnt_r <= 5'h00;
      end else begin
         low_cnt_r <= low_cnt_r + 5'h01;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   AST_RD_RETRY: assert property (
      take && !tgt_we && !tgt_burst && pci_mode && !rd_hit |=>
      tgt_retry && !tgt_done) else $error("read not retried");
   AST_RD_DONE: assert property (
      take && !tgt_we && !tgt_burst && pci_mode && rd_hit |=>
      tgt_done ##1 !tgt_done) else $error("read result not given");
   AST_WR_POST: assert property (
      take && tgt_we && !tgt_burst && pci_mode && !pend
      && tgt_be[1:0] != 2'h0 |=> tgt_done && wr_pend_r)
      else $error("write not posted");
   AST_WR_RETRY: assert property (
      take && tgt_we && !tgt_burst && pci_mode && wr_pend_r |=>
      tgt_retry) else $error("busy write not retried");
   AST_BURST: assert property (
      take && tgt_burst |=> tgt_abort && !tgt_done)
      else $error("burst accepted");
   AST_NOPCI: assert property (
      !pci_mode |-> !local_addr_pins_oe && local_data_pins_oe == 2'h0)
      else $error("pins driven outside pci mode");
   AST_ALE_ORDER: assert property (
      $fell(addr_latch_strobe) |-> read_strobe_n_o && write_strobe_n_o
      ##1 (!read_strobe_n_o || !write_strobe_n_o))
      else $error("command strobe not after latch");
   AST_STROBE_MIN: assert property (
      $fell(read_strobe_n_o && write_strobe_n_o) |->
      !(read_strobe_n_o && write_strobe_n_o) [*2])
      else $error("strobe shorter than two clocks");
   AST_STROBE_LEN: assert property (
      $rose(read_strobe_n_o && write_strobe_n_o) && !cyc_rdy_r |->
      $past(low_cnt_r) == 5'h10 - {1'b0, cyc_ctw_r})
      else $error("strobe length wrong");
   AST_IDLE: assert property (
      state_r == lbus_pkg::ST_IDLE && !wdrive_r && pci_mode |->
      local_data_pins_oe == 2'h0 && read_strobe_n_o && write_strobe_n_o)
      else $error("idle bus not quiet");
   AST_RESET: assert property (
      $past(rst) |-> conf_r[`LB_F_W16] && !conf_r[`LB_F_MUX])
      else $error("reset mode wrong");

   COV_WRITE: cover property (!write_strobe_n_o ##1 write_strobe_n_o);
   COV_READ: cover property (tgt_done && !$past(tgt_we));
   COV_MUX: cover property (addr_latch_strobe);
   COV_HOLD: cover property (!hold_ack_n);
endmodule

// ===== lbus_defs.svh
// register offsets, field positions, reset values and timing counts
`ifndef LBUS_DEFS_SVH
`define LBUS_DEFS_SVH
`define LB_CONF_OFS 8'h00
`define LB_STAT_OFS 8'h04
`define LB_F_CTW_LSB 0
`define LB_F_READY_HANDLING_ENABLE 4
`define LB_F_RWS_LSB 5
`define LB_F_W16 8
`define LB_F_MUX 9
`define LB_F_ARBM 10
`define LB_F_HLDEN 11
`define LB_F_PCI 12
`define LB_CONF_RST 13'h150F
`define LB_CONF_BITS 13
`define LB_STROBE_MIN 5'h02
`define LB_CTW_MAX 5'h0F
`endif

// ===== lbus_pkg.sv
// types shared by the local bus controller
package lbus_pkg;
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_ALE = 6'h02,
      ST_AHOLD = 6'h04,
      ST_STROBE = 6'h08,
      ST_RDY = 6'h10,
      ST_HOLD = 6'h20
   } lb_state_t;
endpackage

// ===== lb_cycle_timer.sv
// down counter that times one command strobe
`timescale 1ns/1ps
module lb_cycle_timer #(
   parameter int W = 5
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic load,
   input wire logic [W-1:0] load_val,
   output logic last
);
   logic [W-1:0] cnt_r;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cnt_r <= '0;
      end else if (load) begin
         cnt_r <= load_val;
      end else if (cnt_r != '0) begin
         cnt_r <= cnt_r - 1'b1;
      end
   end

   // final strobe cycle when one count is left
   assign last = (cnt_r == {{(W-1){1'b0}}, 1'b1});
endmodule

// ===== lb_peer_model.sv
// local bus peer: byte memory with latch, lane decode and ready answer
`timescale 1ns/1ps
module lb_peer_model (
   input wire logic ref_clk,
   input wire logic bus16,
   input wire logic muxed,
   input wire logic [3:0] ready_delay,
   input wire logic [15:0] addr_pins,
   input wire logic [15:0] data_out,
   input wire logic ale,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic bhe_n,
   output logic [15:0] data_drv,
   output logic ready_n
);
   logic [7:0] mem [0:255];
   logic [15:0] lat_r = 16'h0000;
   logic [15:0] noise_r = 16'hA5C3;
   logic [3:0] cnt_r = 4'h0;
   logic [15:0] a;
   logic [7:0] lo;
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'(i) ^ 8'h5A;
      end
   end
   // narrow muxed bus keeps upper address live on upper pins
   assign a = !muxed ? addr_pins :
              bus16 ? lat_r : {data_out[15:8], lat_r[7:0]};
   assign lo = {a[7:1], 1'b0};
   // whole word on a wide bus; noise when released, never held
   assign data_drv = rd_n ? noise_r :
      bus16 ? {mem[lo | 8'h01], mem[lo]} : {noise_r[15:8], mem[a[7:0]]};
   // ready goes low after ready_delay strobe clocks
   assign ready_n = !(!(rd_n && wr_n) && cnt_r >= ready_delay);
   always @(posedge ref_clk) begin
      noise_r <= ~noise_r;
      // external latch takes the address while the strobe is high
      if (ale) begin
         lat_r <= data_out;
      end
      cnt_r <= (rd_n && wr_n) ? 4'h0 : cnt_r + {3'h0, cnt_r != 4'hF};
      if (!wr_n && !bus16) begin
         mem[a[7:0]] <= data_out[7:0];
      end else if (!wr_n) begin
         // low lane by address bit zero, high lane by byte high enable
         if (!a[0]) begin
            mem[lo] <= data_out[7:0];
         end
         if (!bhe_n) begin
            mem[lo | 8'h01] <= data_out[15:8];
         end
      end
   end
endmodule

// ===== pci_to_local_bus_controller_tb.sv
// testbench: wishbone config, host target transfers, local bus checks
`timescale 1ns/1ps
`include "lbus_defs.svh"
module pci_to_local_bus_controller_tb;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, tgt_wdata = 32'h0, tgt_rdata;
   logic [3:0] wb_sel_i = 4'hF, tgt_be = 4'h3, rdy_dly = 4'h0;
   logic tgt_req = 1'b0, tgt_we = 1'b0, tgt_burst = 1'b0, hold_n = 1'b1;
   logic tgt_done, tgt_retry, tgt_abort, la_oe, ale, rd_n, wr_n, bhe_n;
   logic cmd_oe, rdy_n, hold_ack_n, bus_req_n, bus16 = 1'b1, muxed = 1'b0;
   logic [15:0] tgt_addr = 16'h0, la_o, ld_o, ld_i, peer_d;
   logic [1:0] ld_oe;
   logic [31:0] rd;
   int bad_count = 0, n_compared = 0, s_cnt = 0, last_len = 0;
   // each byte lane is resolved from whichever side enables it
   assign ld_i = {ld_oe[1] ? ld_o[15:8] : peer_d[15:8],
                  ld_oe[0] ? ld_o[7:0] : peer_d[7:0]};
   initial forever #50 ref_clk = ~ref_clk;
   pci_to_local_bus_controller dut (.ref_clk(ref_clk), .rst(rst),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tgt_req(tgt_req),
      .tgt_we(tgt_we), .tgt_burst(tgt_burst), .tgt_addr(tgt_addr),
      .tgt_be(tgt_be), .tgt_wdata(tgt_wdata), .tgt_done(tgt_done),
      .tgt_retry(tgt_retry), .tgt_abort(tgt_abort), .tgt_rdata(tgt_rdata),
      .local_addr_pins_o(la_o), .local_addr_pins_oe(la_oe),
      .local_data_pins_i(ld_i), .local_data_pins_o(ld_o),
      .local_data_pins_oe(ld_oe), .addr_latch_strobe(ale),
      .read_strobe_n_o(rd_n), .write_strobe_n_o(wr_n),
      .byte_high_enable_n_o(bhe_n), .cmd_oe(cmd_oe), .ready_in_n(rdy_n),
      .hold_req_n(hold_n), .hold_ack_n(hold_ack_n), .bus_req_n(bus_req_n));
   lb_peer_model peer (.ref_clk(ref_clk), .bus16(bus16), .muxed(muxed),
      .ready_delay(rdy_dly), .addr_pins(la_o), .data_out(ld_o), .ale(ale),
      .rd_n(rd_n), .wr_n(wr_n), .bhe_n(bhe_n), .data_drv(peer_d),
      .ready_n(rdy_n));
   // length of the most recent command strobe, in clocks
   always @(posedge ref_clk) begin
      if (!rd_n || !wr_n) begin
         s_cnt <= s_cnt + 1;
      end else if (s_cnt != 0) begin
         last_len <= s_cnt;
         s_cnt <= 0;
      end
   end
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wb(input logic we, input logic [7:0] adr,
                     input logic [31:0] d, output logic [31:0] q);
      @(posedge ref_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= d;
      do begin
         @(posedge ref_clk);
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   // answer code: 0 done, 1 retry, 2 abort, 3 none
   task automatic host(input logic we, input logic bst, input logic [15:0] a,
      input logic [3:0] be, input logic [31:0] d, output logic [1:0] c);
      c = 2'h3;
      @(posedge ref_clk);
      tgt_req <= 1'b1;
      tgt_we <= we;
      tgt_burst <= bst;
      tgt_addr <= a;
      tgt_be <= be;
      tgt_wdata <= d;
      while (c == 2'h3) begin
         @(posedge ref_clk);
         if (tgt_done === 1'b1) c = 2'h0;
         else if (tgt_retry === 1'b1) c = 2'h1;
         else if (tgt_abort === 1'b1) c = 2'h2;
      end
      rd = tgt_rdata;
      tgt_req <= 1'b0;
      tgt_burst <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic host_rd(input logic [15:0] a, input logic [3:0] be,
                          output logic [1:0] first);
      logic [1:0] c;
      host(1'b0, 1'b0, a, be, 32'h0, c);
      first = c;
      while (c == 2'h1) host(1'b0, 1'b0, a, be, 32'h0, c);
   endtask
   task automatic wait_idle();
      logic [31:0] q;
      do begin
         wb(1'b0, `LB_STAT_OFS, 32'h0, q);
      end while ((q & 32'hE) != 32'h0);
   endtask
   function automatic logic [31:0] cfg(input logic [3:0] ctw,
      input logic w16, input logic mx, input logic rdy, input logic [2:0] rws);
      cfg = {19'h0, 3'h5, mx, w16, rws, rdy, ctw};
   endfunction
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge ref_clk);
      bad_count++;
      conclude();
   end
   initial begin
      logic [31:0] q;
      logic [1:0] c;
      logic [15:0] a, w;
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      wb(1'b0, `LB_CONF_OFS, 32'h0, q);
      check("conf_reset", q, 32'h150F);
      wb(1'b1, 8'h40, 32'hFFFF, q);
      wb(1'b0, 8'h40, 32'h0, q);
      check("unmapped", q, 32'h0);
      $display("test reset done");
      // four bus types, switched between transactions
      for (int m = 0; m < 4; m++) begin
         wb(1'b1, `LB_CONF_OFS, cfg(4'hF, !m[1], m[0], 1'b0, 3'h0), q);
         bus16 <= !m[1];
         muxed <= m[0];
         a = 16'h0020 + 16'(m * 4);
         w = 16'h3C01 + 16'(m) * 16'h1111;
         host(1'b1, 1'b0, a, 4'h3, {16'h0, w}, c);
         check("wr_done", c, 32'h0);
         wait_idle();
         check("wr_hold", {ld_oe[0], ld_o[7:0]}, {1'b1, m[1] ? w[15:8] : w[7:0]});
         check("mem", {peer.mem[a[7:0] + 8'h1], peer.mem[a[7:0]]}, w);
         host_rd(a, 4'h3, c);
         check("rd_first", c, 32'h1);
         check("rd_data", rd, {16'h0, w});
         if (!m[0]) check("idle", {ld_oe, rd_n, wr_n, la_o}, {4'h3, a | 16'(m[1])});
      end
      $display("test bus types done");
      bus16 <= 1'b1;
      muxed <= 1'b0;
      for (int i = 0; i < 3; i++) begin
         wb(1'b1, `LB_CONF_OFS, cfg(4'hF - 4'(i * 6), 1'b1, 1'b0, 1'b0, 3'h0), q);
         host(1'b1, 1'b0, 16'h0040, 4'h3, 32'h1234, c);
         host(1'b1, 1'b0, 16'h0040, 4'h3, 32'h5678, c);
         if (i == 2) check("wr_busy", c, 32'h1);
         wait_idle();
         check("strobe_len", last_len, 2 + i * 6);
      end
      $display("test cycle time done");
      wb(1'b1, `LB_CONF_OFS, cfg(4'hF, 1'b1, 1'b0, 1'b1, 3'h2), q);
      for (int i = 0; i < 2; i++) begin
         rdy_dly <= 4'(i * 6);
         host(1'b1, 1'b0, 16'h0050, 4'h3, 32'h9999, c);
         wait_idle();
         check("rdy_len", last_len >= 4 + i * 4 && last_len <= 8 + i * 6, 1);
      end
      $display("test ready done");
      wb(1'b1, `LB_CONF_OFS, cfg(4'hF, 1'b1, 1'b0, 1'b0, 3'h0), q);
      host(1'b1, 1'b0, 16'h0060, 4'h2, 32'hBEEF, c);
      wait_idle();
      check("byte_hi", {peer.mem[8'h61], peer.mem[8'h60]}, 16'hBE3A);
      host_rd(16'h0060, 4'h1, c);
      check("byte_lo", rd[7:0], 8'h3A);
      $display("test byte lanes done");
      // another master holds the bus; our posted write waits for it
      wb(1'b1, `LB_CONF_OFS, 32'h0000_1D0F, q);
      hold_n <= 1'b0;
      repeat (5) @(posedge ref_clk);
      check("hold_ack", {hold_ack_n, la_oe, cmd_oe}, 32'h0);
      host(1'b1, 1'b0, 16'h0080, 4'h3, 32'h1357, c);
      check("bus_req", {c, bus_req_n, wr_n}, 32'h1);
      hold_n <= 1'b1;
      wait_idle();
      check("after_hold", {peer.mem[8'h81], peer.mem[8'h80]}, 16'h1357);
      $display("test hold done");
      host(1'b0, 1'b1, 16'h0070, 4'h3, 32'h0, c);
      check("burst", c, 32'h2);
      wb(1'b1, `LB_CONF_OFS, 32'h050F, q);
      host(1'b1, 1'b0, 16'h0070, 4'h3, 32'h0, c);
      check("non_pci", c, 32'h2);
      wb(1'b0, `LB_STAT_OFS, 32'h0, q);
      check("stat_mode", q[0], 32'h0);
      $display("test refusals done");
      conclude();
   end
endmodule
